// ### src/mbsrh_defines.vh
// constants of the modbus server request handler: function codes, exception codes, frame layout, crc
// assumes byte-wide request and response streams framed by valid/last strobes
//
// Overview of operation
// [RQ1] copy transaction and protocol identifiers into response
// [RQ2] recompute length field for every response
// [RQ3] echo unit identifier in response header
// [RQ4] tcp accepts 03, 06, 16, 43-14, 100-4
// [RQ5] serial adds function 04 input register read
// [RQ6] functions 1 and 2 are illegal functions
// [RQ7] serial frame: address, pdu, then crc
// [RQ8] intact executable request gets normal response
// [RQ9] communication error: discard, no response at all
// [RQ10] client times out unanswered requests
// [RQ11] intact but unexecutable request gets exception
// [RQ12] exception frame: address, code, exception, check
// [RQ13] exception function code is request plus 0x80
// [RQ14] code 01 for illegal function or state
// [RQ15] code 02 for illegal data address
// [RQ16] code 03 for illegal data value
// [RQ17] code 04 for server device failure
// [RQ18] code 06 when busy with another command
// [RQ19] client retries busy request once server free
// [RQ20] enforce each variable's single access attribute
// [RQ21] write to read-only variable raises exception
// [RQ22] crc-16 over address and pdu, low first
`ifndef MBSRH_DEFINES_VH
`define MBSRH_DEFINES_VH

`define MBSRH_FC_READ_HOLD 8'h03
`define MBSRH_FC_READ_INPUT 8'h04
`define MBSRH_FC_WRITE_ONE 8'h06
`define MBSRH_FC_WRITE_MANY 8'h10
`define MBSRH_FC_IDENT 8'h2b
`define MBSRH_FC_IDENT_SUB 8'h0e
`define MBSRH_FC_NONADJ 8'h64
`define MBSRH_FC_NONADJ_SUB 8'h04
`define MBSRH_FC_EXC_BIT 8'h80

`define MBSRH_EX_ILL_FUNC 8'h01
`define MBSRH_EX_ILL_ADDR 8'h02
`define MBSRH_EX_ILL_VALUE 8'h03
`define MBSRH_EX_DEV_FAIL 8'h04
`define MBSRH_EX_BUSY 8'h06

`define MBSRH_PROTO_MODBUS 16'h0000
`define MBSRH_NONADJ_MAX 8'h64
`define MBSRH_CRC_INIT 16'hffff
`define MBSRH_CRC_POLY 16'ha001
// mbap: trans(2) proto(2) len(2) unit(1); length counts unit + pdu
`define MBSRH_MBAP_LEN 4'h7
`define MBSRH_HDR_MAX 4'h8

`endif

// ### src/mbsrh_crc16.v
// modbus crc-16 engine, one byte per clock
// assumes the caller clears it at frame start and feeds bytes in wire order
`timescale 1ns/1ps
`include "mbsrh_defines.vh"
module mbsrh_crc16 (
	// clock and reset
	input wire i_clock,
	input wire i_rst_b,
	// control
	input wire i_clear,
	input wire i_valid,
	input wire [7:0] i_data,
	// result
	output wire [15:0] o_crc
);
	reg [15:0] crc_ff;
	reg [15:0] nxt_crc;
	integer k;

	always @* begin
		nxt_crc = crc_ff ^ {8'h00, i_data};
		for (k = 0; k < 8; k = k + 1) begin
			if (nxt_crc[0])
				nxt_crc = (nxt_crc >> 1) ^ `MBSRH_CRC_POLY; // RQ22
			else
				nxt_crc = nxt_crc >> 1;
		end
	end

	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b)
			crc_ff <= `MBSRH_CRC_INIT;
		else if (i_clear)
			crc_ff <= `MBSRH_CRC_INIT;
		else if (i_valid)
			crc_ff <= nxt_crc;
	end

	assign o_crc = crc_ff;
endmodule // mbsrh_crc16

// ### src/mbsrh_mem.v
// small request buffer: holds the received pdu for the application
// read data come out of a register one clock after the address
`timescale 1ns/1ps
module mbsrh_mem #(
	parameter DEPTH = 256,
	parameter AW = 8
) (
	// clock
	input wire i_clock,
	// write port
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [7:0] i_wdata,
	// read port
	input wire [AW-1:0] i_raddr,
	output reg [7:0] o_rdata
);
	reg [7:0] mem [0:DEPTH-1];

	always @(posedge i_clock) begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule // mbsrh_mem

// ### src/mbsrh_top.v
// modbus server request handler: parses a request stream, checks it, and emits a response stream
// assumes byte streams synchronous to I_CLOCK; the application supplies verdict and normal-response payload
`timescale 1ns/1ps
`include "mbsrh_defines.vh"
module mbsrh_top #(
	parameter AW = 8
) (
	// clock and reset
	input wire I_CLOCK,
	input wire I_RST_B,
	// configuration
	input wire I_SERIAL_MODE,
	input wire [7:0] I_OWN_ADDR,
	// request stream
	input wire I_RX_VALID,
	input wire [7:0] I_RX_DATA,
	input wire I_RX_LAST,
	input wire I_RX_ERR,
	// application verdict
	input wire I_APP_BUSY,
	input wire I_APP_DONE,
	input wire [7:0] I_APP_EXC,
	input wire [AW-1:0] I_APP_LEN,
	input wire I_APP_DATA_VALID,
	input wire [7:0] I_APP_DATA,
	// request to application
	output reg O_REQ_VALID,
	output reg [7:0] O_REQ_FUNC,
	output reg [AW-1:0] O_REQ_LEN,
	output reg O_REQ_RD_VALID,
	output reg [7:0] O_REQ_RD_DATA,
	// response stream
	output reg O_TX_VALID,
	output reg [7:0] O_TX_DATA,
	output reg O_TX_LAST,
	output reg O_DROP
);
	localparam S_IDLE = 6'b000001;
	localparam S_RECV = 6'b000010;
	localparam S_CHECK = 6'b000100;
	localparam S_WAIT = 6'b001000;
	localparam S_SEND = 6'b010000;
	localparam S_DRAIN = 6'b100000;

	reg [5:0] state_ff;
	reg [AW-1:0] cnt_ff;
	reg [7:0] hdr_ff [0:7];
	reg [7:0] func_ff;
	reg [7:0] sub_ff;
	reg [AW-1:0] pdu_len_ff;
	reg [7:0] exc_ff;
	reg exc_flag_ff;
	reg [AW-1:0] pay_len_ff;
	reg [AW-1:0] tx_idx_ff;
	reg [15:0] rx_crc_ff;
	reg [AW-1:0] rd_idx_ff;
	reg rd_act_ff;
	reg rd_act_d_ff;
	reg [7:0] nxt_tx_data;
	reg [3:0] hdr_n;
	reg [AW-1:0] tot_len;
	reg [15:0] mbap_len;
	reg [7:0] rsp_func;
	reg func_ok;
	reg fc_in;
	wire [7:0] mem_rdata;
	wire [15:0] crc_val;
	wire rx_byte = I_RX_VALID && (state_ff == S_RECV || state_ff == S_IDLE);
	wire [AW-1:0] pdu_idx = cnt_ff - {{(AW-4){1'b0}}, hdr_n};
	integer i;

	// pdu bytes go to the buffer; header bytes live in flip-flops
	mbsrh_mem #(.DEPTH(1 << AW), .AW(AW)) u_mem (
		.i_clock(I_CLOCK),
		.i_we(rx_byte && cnt_ff >= {{(AW-4){1'b0}}, hdr_n}),
		.i_waddr(pdu_idx),
		.i_wdata(I_RX_DATA),
		.i_raddr(rd_idx_ff),
		.o_rdata(mem_rdata)
	);

	// crc covers received bytes, then on serial is reused for the outgoing frame
	mbsrh_crc16 u_crc (
		.i_clock(I_CLOCK),
		.i_rst_b(I_RST_B),
		.i_clear(state_ff == S_CHECK || (state_ff == S_IDLE && !I_RX_VALID)),
		.i_valid(rx_byte || (state_ff == S_SEND && tx_step && I_SERIAL_MODE && tx_idx_ff < tot_len - 2'd2)),
		.i_data(rx_byte ? I_RX_DATA : nxt_tx_data),
		.o_crc(crc_val)
	);

	// serial: address only; tcp: 7-byte mbap
	always @* begin
		hdr_n = I_SERIAL_MODE ? 4'h1 : `MBSRH_MBAP_LEN; // RQ7
	end

	// function screening
	always @* begin
		fc_in = (func_ff == `MBSRH_FC_READ_HOLD) || (func_ff == `MBSRH_FC_WRITE_ONE) ||
			(func_ff == `MBSRH_FC_WRITE_MANY) ||
			(func_ff == `MBSRH_FC_IDENT && sub_ff == `MBSRH_FC_IDENT_SUB) ||
			(func_ff == `MBSRH_FC_NONADJ && sub_ff == `MBSRH_FC_NONADJ_SUB); // RQ4
		func_ok = fc_in || (I_SERIAL_MODE && func_ff == `MBSRH_FC_READ_INPUT); // RQ5 RQ6
	end

	// response length: header + function + body (+ crc on serial)
	always @* begin
		rsp_func = exc_flag_ff ? (func_ff | `MBSRH_FC_EXC_BIT) : func_ff; // RQ13
		tot_len = {{(AW-4){1'b0}}, hdr_n} + 1'b1 + (exc_flag_ff ? {{(AW-1){1'b0}}, 1'b1} : pay_len_ff) +
			(I_SERIAL_MODE ? {{(AW-2){1'b0}}, 2'd2} : {AW{1'b0}}); // RQ12
		mbap_len = {{(16-AW){1'b0}}, (exc_flag_ff ? {{(AW-1){1'b0}}, 1'b1} : pay_len_ff)} + 16'h0002; // RQ2
	end

	always @* begin
		nxt_tx_data = 8'h00;
		if (I_SERIAL_MODE) begin
			if (tx_idx_ff == 0)
				nxt_tx_data = hdr_ff[0]; // RQ7
			else if (tx_idx_ff == 1)
				nxt_tx_data = rsp_func;
			else if (tx_idx_ff == tot_len - 2'd2)
				nxt_tx_data = crc_val[7:0]; // RQ22
			else if (tx_idx_ff == tot_len - 1'b1)
				nxt_tx_data = crc_val[15:8];
			else
				nxt_tx_data = exc_flag_ff ? exc_ff : I_APP_DATA;
		end else begin
			case (tx_idx_ff)
				0, 1, 2, 3: nxt_tx_data = hdr_ff[tx_idx_ff[1:0]]; // RQ1
				4: nxt_tx_data = mbap_len[15:8]; // RQ2
				5: nxt_tx_data = mbap_len[7:0];
				6: nxt_tx_data = hdr_ff[6]; // RQ3
				7: nxt_tx_data = rsp_func;
				default: nxt_tx_data = exc_flag_ff ? exc_ff : I_APP_DATA;
			endcase
		end
	end

	// a payload byte needs the application's strobe; header, code, exception and crc bytes do not
	wire tx_body = !exc_flag_ff && tx_idx_ff > {{(AW-4){1'b0}}, hdr_n} &&
		(!I_SERIAL_MODE || tx_idx_ff < tot_len - 2'd2);
	wire tx_step = !tx_body || I_APP_DATA_VALID;

	always @(posedge I_CLOCK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_ff <= S_IDLE;
			cnt_ff <= {AW{1'b0}};
			for (i = 0; i < 8; i = i + 1)
				hdr_ff[i] <= 8'h00;
			func_ff <= 8'h00;
			sub_ff <= 8'h00;
			pdu_len_ff <= {AW{1'b0}};
			exc_ff <= 8'h00;
			exc_flag_ff <= 1'b0;
			pay_len_ff <= {AW{1'b0}};
			tx_idx_ff <= {AW{1'b0}};
			rx_crc_ff <= 16'h0000;
			rd_idx_ff <= {AW{1'b0}};
			rd_act_ff <= 1'b0;
			rd_act_d_ff <= 1'b0;
			O_REQ_VALID <= 1'b0;
			O_REQ_FUNC <= 8'h00;
			O_REQ_LEN <= {AW{1'b0}};
			O_REQ_RD_VALID <= 1'b0;
			O_REQ_RD_DATA <= 8'h00;
			O_TX_VALID <= 1'b0;
			O_TX_DATA <= 8'h00;
			O_TX_LAST <= 1'b0;
			O_DROP <= 1'b0;
		end else begin
			O_REQ_VALID <= 1'b0;
			O_TX_VALID <= 1'b0;
			O_TX_LAST <= 1'b0;
			O_DROP <= 1'b0;
			// buffer output is registered: valid lags the read address by two clocks
			rd_act_d_ff <= rd_act_ff;
			O_REQ_RD_VALID <= rd_act_d_ff;
			O_REQ_RD_DATA <= mem_rdata;
			if (rd_act_ff) begin
				if (rd_idx_ff + 1'b1 >= pdu_len_ff)
					rd_act_ff <= 1'b0;
				rd_idx_ff <= rd_idx_ff + 1'b1;
			end
			case (state_ff)
				S_IDLE, S_RECV: begin
					if (I_RX_VALID) begin
						state_ff <= S_RECV;
						cnt_ff <= cnt_ff + 1'b1;
						if (cnt_ff < {{(AW-4){1'b0}}, hdr_n})
							hdr_ff[cnt_ff[2:0]] <= I_RX_DATA;
						if (cnt_ff == {{(AW-4){1'b0}}, hdr_n})
							func_ff <= I_RX_DATA;
						if (cnt_ff == {{(AW-4){1'b0}}, hdr_n} + 1'b1)
							sub_ff <= I_RX_DATA;
						// keep the last two received bytes, newest in the high byte: on serial these are the check itself
						rx_crc_ff <= {I_RX_DATA, rx_crc_ff[15:8]};
						if (I_RX_LAST) begin
							state_ff <= S_CHECK;
							pdu_len_ff <= cnt_ff + 1'b1 - {{(AW-4){1'b0}}, hdr_n} -
								(I_SERIAL_MODE ? {{(AW-2){1'b0}}, 2'd2} : {AW{1'b0}});
						end
					end
				end
				S_CHECK: begin
					cnt_ff <= {AW{1'b0}};
					tx_idx_ff <= {AW{1'b0}};
					// crc register now holds crc over the check bytes too: zero means intact
					if (I_RX_ERR || (I_SERIAL_MODE && (crc_val != 16'h0000 || hdr_ff[0] != I_OWN_ADDR)) ||
						(!I_SERIAL_MODE && {hdr_ff[2], hdr_ff[3]} != `MBSRH_PROTO_MODBUS)) begin
						O_DROP <= 1'b1; // RQ9 RQ22
						state_ff <= S_IDLE;
					end else if (I_APP_BUSY) begin
						exc_flag_ff <= 1'b1;
						exc_ff <= `MBSRH_EX_BUSY; // RQ18
						state_ff <= S_SEND;
					end else if (!func_ok) begin
						exc_flag_ff <= 1'b1;
						exc_ff <= `MBSRH_EX_ILL_FUNC; // RQ6 RQ14
						state_ff <= S_SEND;
					end else begin
						exc_flag_ff <= 1'b0;
						O_REQ_VALID <= 1'b1; // RQ8
						O_REQ_FUNC <= func_ff;
						O_REQ_LEN <= pdu_len_ff;
						rd_idx_ff <= {AW{1'b0}};
						rd_act_ff <= 1'b1;
						state_ff <= S_WAIT;
					end
				end
				S_WAIT: begin
					// application reports 02/03/04, or a write to a read-only variable, as i_app_exc
					if (I_APP_DONE) begin
						exc_flag_ff <= (I_APP_EXC != 8'h00); // RQ11 RQ15 RQ16 RQ17 RQ20 RQ21
						exc_ff <= I_APP_EXC;
						pay_len_ff <= I_APP_LEN;
						state_ff <= S_SEND;
					end
				end
				S_SEND: begin
					if (tx_step) begin
						O_TX_VALID <= 1'b1;
						O_TX_DATA <= nxt_tx_data;
						tx_idx_ff <= tx_idx_ff + 1'b1;
						if (tx_idx_ff == tot_len - 1'b1) begin
							O_TX_LAST <= 1'b1;
							state_ff <= S_DRAIN;
						end
					end
				end
				S_DRAIN: begin
					exc_flag_ff <= 1'b0;
					state_ff <= S_IDLE;
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule // mbsrh_top

// ### dv/mbsrh_monitor.sv
// port checker for the request handler top
// assumes serial frames and a zero-length response body
`timescale 1ns/1ps
module mbsrh_monitor (
	// clock and reset
	input wire I_CLOCK,
	input wire I_RST_B,
	// watched inputs
	input wire I_RX_VALID,
	input wire I_RX_LAST,
	input wire I_RX_ERR,
	input wire I_APP_BUSY,
	input wire I_APP_DONE,
	input wire I_APP_DATA_VALID,
	// watched outputs
	input wire O_REQ_VALID,
	input wire [7:0] O_REQ_FUNC,
	input wire O_REQ_RD_VALID,
	input wire [7:0] O_REQ_RD_DATA,
	input wire O_TX_VALID,
	input wire O_TX_LAST,
	input wire O_DROP
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_B);
	a_err_drops: assert property (I_RX_VALID && I_RX_LAST ##1 I_RX_ERR |-> ##[0:1] O_DROP)
		else $error("comm error not dropped");
	a_drop_is_silent: assert property (O_DROP |-> !O_TX_VALID [*4])
		else $error("response after drop");
	a_drop_req_excl: assert property (!(O_DROP && O_REQ_VALID))
		else $error("drop and accept together");
	a_drop_after_last: assert property (O_DROP |-> $past(I_RX_LAST) || $past(I_RX_LAST, 2))
		else $error("drop without frame end");
	a_busy_no_req: assert property (I_RX_VALID && I_RX_LAST ##1 I_APP_BUSY |-> !O_REQ_VALID ##1 !O_REQ_VALID)
		else $error("busy request accepted");
	a_req_streams_fc: assert property (O_REQ_VALID |-> ##2 O_REQ_RD_VALID && O_REQ_RD_DATA == $past(O_REQ_FUNC, 2))
		else $error("pdu stream not led by function code");
	a_done_starts_tx: assert property (I_APP_DONE |-> ##[1:2] O_TX_VALID)
		else $error("verdict gave no response");
	a_tx_last_ends: assert property (O_TX_LAST |-> O_TX_VALID ##1 !O_TX_VALID)
		else $error("bytes after final byte");
	a_tx_contiguous: assert property (O_TX_VALID && !O_TX_LAST && I_APP_DATA_VALID |=> O_TX_VALID)
		else $error("gap inside response");
endmodule // mbsrh_monitor

bind mbsrh_top mbsrh_monitor mbsrh_monitor_inst (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_RX_VALID(I_RX_VALID),
	.I_RX_LAST(I_RX_LAST), .I_RX_ERR(I_RX_ERR), .I_APP_BUSY(I_APP_BUSY), .I_APP_DONE(I_APP_DONE),
	.I_APP_DATA_VALID(I_APP_DATA_VALID), .O_REQ_VALID(O_REQ_VALID), .O_REQ_FUNC(O_REQ_FUNC),
	.O_REQ_RD_VALID(O_REQ_RD_VALID), .O_REQ_RD_DATA(O_REQ_RD_DATA), .O_TX_VALID(O_TX_VALID),
	.O_TX_LAST(O_TX_LAST), .O_DROP(O_DROP));

// ### dv/mbsrh_client.sv
// remote client model on a serial line or tcp link: sends framed requests, collects responses
// assumes one frame at a time, started by the bench
`timescale 1ns/1ps
module mbsrh_client (
	// clock
	input wire i_clock,
	// response stream
	input wire i_tx_valid,
	input wire [7:0] i_tx_data,
	input wire i_tx_last,
	// request stream
	output reg o_rx_valid,
	output reg [7:0] o_rx_data,
	output reg o_rx_last,
	output reg o_rx_err
);
	logic [7:0] resp[$];
	bit got_last;
	initial begin
		o_rx_valid = 0; o_rx_data = 8'h00; o_rx_last = 0; o_rx_err = 0;
	end
	function automatic logic [15:0] crc16(input logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i]) begin
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	always @(posedge i_clock) if (i_tx_valid) begin
		resp.push_back(i_tx_data);
		if (i_tx_last) got_last = 1;
	end
	// bad flips the low bit of the check so the frame must be refused
	task send(input logic [7:0] f[$], input bit bad, input bit err);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		send_raw(f, err);
	endtask
	// tcp frames carry no check bytes
	task send_raw(input logic [7:0] f[$], input bit err);
		resp.delete();
		got_last = 0;
		o_rx_err = err;
		foreach (f[i]) begin
			@(posedge i_clock); #1;
			o_rx_valid = 1; o_rx_data = f[i]; o_rx_last = (i == f.size() - 1);
		end
		@(posedge i_clock); #1;
		// released data is inverted so a stale byte never looks valid
		o_rx_valid = 0; o_rx_last = 0; o_rx_data = ~o_rx_data;
	endtask
endmodule // mbsrh_client

// ### dv/mbsrh_tb.sv
// self-checking bench for the request handler in serial and tcp modes
// assumes the client model and the port checker are compiled alongside
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] A = 8'h11;
	reg clk = 0, rst_b = 0, busy = 0, done = 0, drop_f = 0, ser = 1;
	reg [7:0] exc = 8'h00, req_f = 8'h00;
	wire rv, rl, re, qv, tv, tl, drop;
	wire [7:0] rd, qf, td;
	int num_errors = 0, checks = 0, cyc = 0;
	mbsrh_top mbsrh_top_inst (.I_CLOCK(clk), .I_RST_B(rst_b), .I_SERIAL_MODE(ser), .I_OWN_ADDR(A),
		.I_RX_VALID(rv), .I_RX_DATA(rd), .I_RX_LAST(rl), .I_RX_ERR(re), .I_APP_BUSY(busy), .I_APP_DONE(done),
		.I_APP_EXC(exc), .I_APP_LEN(8'h00), .I_APP_DATA_VALID(1'b1), .I_APP_DATA(8'h00), .O_REQ_VALID(qv),
		.O_REQ_FUNC(qf), .O_REQ_LEN(), .O_REQ_RD_VALID(), .O_REQ_RD_DATA(), .O_TX_VALID(tv), .O_TX_DATA(td),
		.O_TX_LAST(tl), .O_DROP(drop));
	mbsrh_client mbsrh_client_inst (.i_clock(clk), .i_tx_valid(tv), .i_tx_data(td), .i_tx_last(tl),
		.o_rx_valid(rv), .o_rx_data(rd), .o_rx_last(rl), .o_rx_err(re));
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		if (qv) req_f <= qf;
		if (drop) drop_f <= 1;
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// waits a bounded time, as a client's reply timeout would
	task resp_is(input logic [7:0] e[$]);
		logic [15:0] c;
		c = mbsrh_client_inst.crc16(e);
		if (ser) begin
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		repeat (40) if (!mbsrh_client_inst.got_last) @(posedge clk);
		cmp(8'(mbsrh_client_inst.resp.size()), 8'(e.size()));
		foreach (e[i]) cmp(mbsrh_client_inst.resp[i], e[i]);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task app_ok(input logic [7:0] f, input logic [7:0] x);
		repeat (3) @(posedge clk);
		#1;
		cmp(req_f, f);
		exc = x; done = 1;
		@(posedge clk); #1;
		done = 0;
	endtask
	task t_funcs();
		logic [7:0] fc[6] = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h2b, 8'h64};
		logic [7:0] sb[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h04};
		logic [7:0] ex[6] = '{8'h00, 8'h02, 8'h04, 8'h03, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			req_f = 8'h00;
			mbsrh_client_inst.send('{A, fc[i], sb[i], 8'h00, 8'h00, 8'h01}, 0, 0);
			app_ok(fc[i], ex[i]);
			if (ex[i] == 8'h00) resp_is('{A, fc[i]});
			else resp_is('{A, fc[i] | 8'h80, ex[i]});
		end
	endtask
	task t_bad();
		logic [7:0] fc[3] = '{8'h01, 8'h02, 8'h2b};
		for (int i = 0; i < 3; i++) begin
			mbsrh_client_inst.send('{A, fc[i], 8'h0d, 8'h00, 8'h00, 8'h01}, 0, 0);
			resp_is('{A, fc[i] | 8'h80, 8'h01});
		end
	endtask
	task t_drop();
		for (int i = 0; i < 3; i++) begin
			drop_f = 0;
			mbsrh_client_inst.send('{(i == 2) ? 8'h12 : A, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, i == 0, i == 1);
			repeat (8) @(posedge clk);
			#1;
			cmp({7'h00, drop_f}, 8'h01);
			cmp(8'(mbsrh_client_inst.resp.size()), 8'h00);
		end
	endtask
	task t_busy();
		busy = 1;
		mbsrh_client_inst.send('{A, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 0, 0);
		resp_is('{A, 8'h83, 8'h06});
		busy = 0;
		req_f = 8'h00;
		mbsrh_client_inst.send('{A, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 0, 0);
		app_ok(8'h03, 8'h00);
		resp_is('{A, 8'h03});
	endtask
	task t_tcp();
		ser = 0;
		req_f = 8'h00;
		mbsrh_client_inst.send_raw('{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h06, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
		app_ok(8'h03, 8'h00);
		resp_is('{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h02, 8'h05, 8'h03});
		mbsrh_client_inst.send_raw('{8'h56, 8'h78, 8'h00, 8'h00, 8'h00, 8'h06, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
		resp_is('{8'h56, 8'h78, 8'h00, 8'h00, 8'h00, 8'h03, 8'h09, 8'h81, 8'h01});
		drop_f = 0;
		mbsrh_client_inst.send_raw('{8'h12, 8'h34, 8'h00, 8'h01, 8'h00, 8'h06, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
		repeat (8) @(posedge clk);
		#1;
		cmp({7'h00, drop_f}, 8'h01);
		cmp(8'(mbsrh_client_inst.resp.size()), 8'h00);
	endtask
	task close_out();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_b = 1;
		t_funcs();
		t_bad();
		t_drop();
		t_busy();
		t_tcp();
		close_out();
	end
endmodule // tb
